/* File: logic/rsm_pkg.sv */
package rsm_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;

   // write key, bits 31..24 of command and mode writes
   localparam int KEY_LSB = 24;
   localparam logic [7:0] KEY_VAL = 8'hA5;

   // command bits
   localparam int CMD_CORE = 0;
   localparam int CMD_PERIPH = 2;
   localparam int CMD_PIN = 3;

   // status bits
   localparam int ST_USER_SEEN = 0;
   localparam int ST_BROWN_SEEN = 1;
   localparam int ST_CAUSE_LSB = 8;
   localparam int ST_PIN_LEVEL = 16;
   localparam int ST_SW_BUSY = 17;

   // mode bits
   localparam int MD_USER_EN = 0;
   localparam int MD_USER_IRQ = 4;
   localparam int MD_LEN_LSB = 8;
   localparam int MD_BROWN_IRQ = 16;

   // last reset cause codes
   localparam logic [2:0] CAUSE_POWERUP = 3'h0;
   localparam logic [2:0] CAUSE_WDOG = 3'h2;
   localparam logic [2:0] CAUSE_SOFT = 3'h3;
   localparam logic [2:0] CAUSE_USER = 3'h4;
   localparam logic [2:0] CAUSE_BROWN = 3'h5;

   // reset states last three slow ticks, user and brownout after their hold: counts 0,1,2
   localparam logic [1:0] STATE_LAST_TICK = 2'h2;
   // master cycles the pin stays masked after the driver lets go
   localparam logic [2:0] PIN_MASK_CYC = 3'h4;

   // mode register contents
   typedef struct packed {
      logic brown_irq_enable;
      logic [3:0] ext_reset_length;
      logic user_reset_irq_enable;
      logic user_reset_enable;
   } rsm_mode_t;

   typedef enum logic [2:0] {
      ST_RUN, ST_PWRUP, ST_BROWN, ST_WDOG, ST_SOFT, ST_USER
   } rsm_state_t;

endpackage

/* File: logic/rsm_reset_state_manager.sv */
// Operation
// RULE1 - watchdog reset lasts exactly three slow ticks
// RULE2 - core-only clear: core, periph, pin reset
// RULE3 - core-only set: only core reset
// RULE4 - watchdog reset disabled: fault ignored
// RULE5 - priority powerup, brownout, watchdog, software, user
// RULE6 - watchdog preempts software; pin ignored
// RULE7 - no user reset during watchdog reset
// RULE8 - user reset holds core in reset
// RULE9 - software busy bit 17 while command runs
// RULE10 - bit 16 shows sampled pin level
// RULE11 - pin falling edge sets bit 0
// RULE12 - user flag interrupt when enabled, reset off
// RULE13 - brownout flag when brownout reset disabled
// RULE14 - command and mode need key 0xA5
// RULE15 - command bits 0,2,3 start resets
// RULE16 - cause codes in status bits 10..8
// RULE17 - status read keeps cause field
// RULE18 - mode bit 0 enables user reset
// RULE19 - pin held low 2^(len+1) slow ticks
// RULE20 - mode bits 4,16 gate interrupt flags
// RULE21 - software reset lasts three slow ticks
// RULE22 - command writes ignored while busy
// RULE23 - cause loaded at core reset release
// RULE24 - fault and pin synchronised first
//
// The APB register port was chosen for this implementation.
module rsm_reset_state_manager (
   // clock, reset, enable
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_clk_en,
   // slow clock tick, one master cycle per slow period
   input wire logic i_slow_tick,
   // watchdog side
   input wire logic i_wdog_fault,
   input wire logic i_watchdog_reset_enable,
   input wire logic i_watchdog_core_only,
   // brownout side
   input wire logic i_brownout,
   input wire logic i_brownout_reset_enable,
   // external reset pin
   input wire logic i_nrst_in,
   output logic o_nrst_out,
   output logic o_nrst_oe,
   // reset outputs
   output logic o_core_reset_n,
   output logic o_periph_reset_n,
   output logic o_irq,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [31:0] o_prdata
);

   // two-flop synchronisers plus a history flop for edges
   logic [2:0] pin_q, wdf_q, bod_q;
   logic pin_s, pin_fall, wdf_rise, bod_s, bod_rise;

   // synchronisers; only stage 1 and later are read
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pin_q <= 3'h7;
         wdf_q <= 3'h0;
         bod_q <= 3'h0;
      end else if (i_clk_en) begin
         pin_q <= {pin_q[1:0], i_nrst_in}; // RULE24
         wdf_q <= {wdf_q[1:0], i_wdog_fault}; // RULE24
         bod_q <= {bod_q[1:0], i_brownout};
      end
   end

   // edges from the settled stages only
   assign pin_s = pin_q[1];
   assign pin_fall = pin_q[2] & ~pin_q[1];
   assign wdf_rise = wdf_q[1] & ~wdf_q[2];
   assign bod_s = bod_q[1];
   assign bod_rise = bod_q[1] & ~bod_q[2];

   // bus side state
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   rsm_pkg::rsm_mode_t mode_q, mode_d;
   logic user_seen_q, user_seen_d;
   logic brown_seen_q, brown_seen_d;
   logic pin_level_q, pin_level_d;
   logic irq_q, irq_d;

   // reset side state
   rsm_pkg::rsm_state_t st_q, st_d;
   logic [1:0] cnt_q, cnt_d;
   logic core_rst_q, core_rst_d;
   logic per_rst_q, per_rst_d;
   logic [2:0] pend_q, pend_d;
   logic [2:0] cause_q, cause_d;
   logic [16:0] ext_cnt_q, ext_cnt_d;
   logic ext_on_q, ext_on_d;
   logic [2:0] mask_q, mask_d;

   // decoded bus strobes
   logic acc, key_ok, hit_cmd, hit_st, hit_md, mapped;
   logic cmd_wr, st_rd, md_wr, sw_busy;
   logic [31:0] status_word;

   // pin drive length in slow ticks
   function automatic logic [16:0] ext_len(input logic [3:0] len);
      ext_len = 17'h00002 << len; // RULE19
   endfunction

   assign acc = i_psel & i_penable & pready_q;
   assign key_ok = (i_pwdata[31:rsm_pkg::KEY_LSB] == rsm_pkg::KEY_VAL);
   assign hit_cmd = (i_paddr == rsm_pkg::OFS_CMD);
   assign hit_st = (i_paddr == rsm_pkg::OFS_STATUS);
   assign hit_md = (i_paddr == rsm_pkg::OFS_MODE);
   assign mapped = hit_cmd | hit_st | hit_md;
   assign sw_busy = (st_q == rsm_pkg::ST_SOFT);
   assign cmd_wr = acc & i_pwrite & hit_cmd & key_ok & ~sw_busy; // RULE14 RULE22
   assign st_rd = acc & ~i_pwrite & hit_st;
   assign md_wr = acc & i_pwrite & hit_md & key_ok; // RULE14

   // status word as software sees it
   always_comb begin
      status_word = 32'h00000000;
      status_word[rsm_pkg::ST_USER_SEEN] = user_seen_q;
      status_word[rsm_pkg::ST_BROWN_SEEN] = brown_seen_q;
      status_word[rsm_pkg::ST_CAUSE_LSB +: 3] = cause_q; // RULE16 RULE17
      status_word[rsm_pkg::ST_PIN_LEVEL] = pin_level_q; // RULE10
      status_word[rsm_pkg::ST_SW_BUSY] = sw_busy; // RULE9
   end

   // bus next state: one wait state, so every output is a flop
   always_comb begin
      pready_d = i_psel & i_penable & ~pready_q;
      pslverr_d = pready_d & ~mapped;
      prdata_d = prdata_q;
      if (pready_d) begin
         prdata_d = 32'h00000000;
         if (!i_pwrite && hit_st) begin
            prdata_d = status_word;
         end else if (!i_pwrite && hit_md) begin
            prdata_d[rsm_pkg::MD_USER_EN] = mode_q.user_reset_enable;
            prdata_d[rsm_pkg::MD_USER_IRQ] = mode_q.user_reset_irq_enable;
            prdata_d[rsm_pkg::MD_LEN_LSB +: 4] = mode_q.ext_reset_length;
            prdata_d[rsm_pkg::MD_BROWN_IRQ] = mode_q.brown_irq_enable;
         end
      end
      mode_d = mode_q;
      if (md_wr) begin
         mode_d.user_reset_enable = i_pwdata[rsm_pkg::MD_USER_EN];
         mode_d.user_reset_irq_enable = i_pwdata[rsm_pkg::MD_USER_IRQ];
         mode_d.ext_reset_length = i_pwdata[rsm_pkg::MD_LEN_LSB +: 4];
         mode_d.brown_irq_enable = i_pwdata[rsm_pkg::MD_BROWN_IRQ];
      end
      pin_level_d = pin_s; // RULE10
      // a read clears the flags; a new event in that cycle wins
      user_seen_d = (user_seen_q & ~st_rd) | pin_fall; // RULE11
      brown_seen_d = (brown_seen_q & ~st_rd) | (bod_rise & ~i_brownout_reset_enable); // RULE13
      irq_d = (user_seen_d & ~mode_d.user_reset_enable & mode_d.user_reset_irq_enable) // RULE12
         | (brown_seen_d & mode_d.brown_irq_enable); // RULE20
   end

   // bus registers
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
         mode_q <= '0;
         user_seen_q <= 1'b0;
         brown_seen_q <= 1'b0;
         pin_level_q <= 1'b1;
         irq_q <= 1'b0;
      end else if (i_clk_en) begin
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
         mode_q <= mode_d;
         user_seen_q <= user_seen_d;
         brown_seen_q <= brown_seen_d;
         pin_level_q <= pin_level_d;
         irq_q <= irq_d;
      end
   end

   // requests into the state manager
   logic pin_mask, brown_req, wdog_req, user_req, ext_start;
   assign pin_mask = ext_on_q | (mask_q != 3'h0); // RULE2
   assign brown_req = bod_s & i_brownout_reset_enable;
   assign wdog_req = wdf_rise & i_watchdog_reset_enable; // RULE4
   assign user_req = ~pin_s & mode_q.user_reset_enable & ~pin_mask; // RULE18

   // reset state next values
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      core_rst_d = core_rst_q;
      per_rst_d = per_rst_q;
      pend_d = pend_q;
      cause_d = cause_q;
      ext_start = 1'b0;
      if (i_slow_tick) begin
         cnt_d = cnt_q + 2'h1;
      end
      // fixed priority; power-up is never preempted
      if (st_q != rsm_pkg::ST_PWRUP && st_q != rsm_pkg::ST_BROWN && brown_req) begin // RULE5
         st_d = rsm_pkg::ST_BROWN;
         cnt_d = 2'h0;
         core_rst_d = 1'b1;
         per_rst_d = 1'b1;
         pend_d = rsm_pkg::CAUSE_BROWN;
         ext_start = 1'b1;
      end else if (wdog_req && (st_q == rsm_pkg::ST_RUN || st_q == rsm_pkg::ST_SOFT)) begin // RULE6
         st_d = rsm_pkg::ST_WDOG;
         cnt_d = 2'h0;
         core_rst_d = 1'b1;
         per_rst_d = ~i_watchdog_core_only; // RULE2 RULE3
         pend_d = rsm_pkg::CAUSE_WDOG;
         ext_start = ~i_watchdog_core_only; // RULE2
      end else if (st_q == rsm_pkg::ST_RUN && cmd_wr) begin // RULE15
         if (i_pwdata[rsm_pkg::CMD_CORE] | i_pwdata[rsm_pkg::CMD_PERIPH]
               | i_pwdata[rsm_pkg::CMD_PIN]) begin
            st_d = rsm_pkg::ST_SOFT;
            cnt_d = 2'h0;
            core_rst_d = i_pwdata[rsm_pkg::CMD_CORE];
            per_rst_d = i_pwdata[rsm_pkg::CMD_PERIPH];
            pend_d = rsm_pkg::CAUSE_SOFT;
            ext_start = i_pwdata[rsm_pkg::CMD_PIN];
         end
      end else if (st_q == rsm_pkg::ST_RUN && user_req) begin // RULE7
         st_d = rsm_pkg::ST_USER;
         cnt_d = 2'h0;
         core_rst_d = 1'b1; // RULE8
         per_rst_d = 1'b1;
         pend_d = rsm_pkg::CAUSE_USER;
      end else begin
         unique case (st_q)
            rsm_pkg::ST_RUN: begin
               cnt_d = 2'h0;
            end
            rsm_pkg::ST_USER: begin
               // held while the pin stays low, then three ticks
               if (!pin_s) begin
                  cnt_d = 2'h0;
               end
            end
            rsm_pkg::ST_BROWN: begin
               if (bod_s) begin
                  cnt_d = 2'h0;
               end
            end
            rsm_pkg::ST_PWRUP, rsm_pkg::ST_WDOG, rsm_pkg::ST_SOFT: begin
            end
         endcase
         // leave after the third tick of the state
         if (st_q != rsm_pkg::ST_RUN && i_slow_tick
               && cnt_q == rsm_pkg::STATE_LAST_TICK) begin // RULE1 RULE21
            st_d = rsm_pkg::ST_RUN;
            cnt_d = 2'h0;
            core_rst_d = 1'b0;
            per_rst_d = 1'b0;
            if (core_rst_q) begin
               cause_d = pend_q; // RULE23
            end
         end
      end
   end

   // pin driver length and the self-reset mask
   always_comb begin
      ext_cnt_d = ext_cnt_q;
      if (ext_start) begin
         ext_cnt_d = ext_len(mode_q.ext_reset_length); // RULE19
      end else if (i_slow_tick && ext_cnt_q != 17'h00000) begin
         ext_cnt_d = ext_cnt_q - 17'h00001;
      end
      ext_on_d = (ext_cnt_d != 17'h00000);
      // the synchroniser lags the pin; mask covers that lag
      if (ext_on_q) begin
         mask_d = rsm_pkg::PIN_MASK_CYC;
      end else if (mask_q != 3'h0) begin
         mask_d = mask_q - 3'h1;
      end else begin
         mask_d = 3'h0;
      end
   end

   // reset state registers; power-up state held for three ticks
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= rsm_pkg::ST_PWRUP;
         cnt_q <= 2'h0;
         core_rst_q <= 1'b1;
         per_rst_q <= 1'b1;
         pend_q <= rsm_pkg::CAUSE_POWERUP;
         cause_q <= rsm_pkg::CAUSE_POWERUP;
         ext_cnt_q <= 17'h00000;
         ext_on_q <= 1'b0;
         mask_q <= 3'h0;
      end else if (i_clk_en) begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         core_rst_q <= core_rst_d;
         per_rst_q <= per_rst_d;
         pend_q <= pend_d;
         cause_q <= cause_d;
         ext_cnt_q <= ext_cnt_d;
         ext_on_q <= ext_on_d;
         mask_q <= mask_d;
      end
   end

   // outputs, all straight from flops; pin is open drain, low only
   assign o_nrst_out = 1'b0 & ext_on_q;
   assign o_nrst_oe = ext_on_q;
   assign o_core_reset_n = ~core_rst_q;
   assign o_periph_reset_n = ~per_rst_q;
   assign o_irq = irq_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_prdata = prdata_q;

   // checks
   sequence s_wdog_entry;
      st_q != rsm_pkg::ST_WDOG ##1 st_q == rsm_pkg::ST_WDOG;
   endsequence

   sequence s_last_tick(rsm_pkg::rsm_state_t s);
      st_q == s && i_slow_tick && cnt_q == rsm_pkg::STATE_LAST_TICK;
   endsequence

   a_wdog_exit: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE1
      s_last_tick(rsm_pkg::ST_WDOG) and (i_clk_en && !brown_req) |=> st_q == rsm_pkg::ST_RUN)
      else $error("watchdog reset did not end on third tick");

   a_wdog_full: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE2
      s_wdog_entry ##0 $past(!i_watchdog_core_only) |->
         !o_core_reset_n && !o_periph_reset_n && o_nrst_oe)
      else $error("full watchdog reset missing an output");

   a_wdog_core: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE3
      s_wdog_entry ##0 $past(i_watchdog_core_only) |->
         !o_core_reset_n && o_periph_reset_n)
      else $error("core-only watchdog reset touched peripherals");

   a_wdog_off: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE4
      i_clk_en && !i_watchdog_reset_enable && st_q == rsm_pkg::ST_RUN && !brown_req
         && !cmd_wr && !user_req |=> st_q == rsm_pkg::ST_RUN)
      else $error("watchdog fault acted while disabled");

   a_no_user_wdog: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE7
      st_q == rsm_pkg::ST_WDOG |=> st_q != rsm_pkg::ST_USER)
      else $error("user reset entered from watchdog reset");

   a_cmd_busy: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE22
      i_clk_en && acc && i_pwrite && hit_cmd && sw_busy && !i_slow_tick && !brown_req
         && !wdog_req |=> $stable(cnt_q) && $stable(core_rst_q) && $stable(per_rst_q))
      else $error("command accepted while busy");

   a_cause_read: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE17
      st_rd && st_q == rsm_pkg::ST_RUN |=> $stable(cause_q))
      else $error("status read changed cause");

   a_key_guard: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE14
      acc && i_pwrite && hit_md && !key_ok |=> $stable(mode_q))
      else $error("mode written with wrong key");

   a_irq_user: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE12
      i_clk_en && user_seen_q && !st_rd && !mode_q.user_reset_enable
         && mode_q.user_reset_irq_enable && !md_wr |=> o_irq)
      else $error("user flag interrupt missing");

   a_flag_set: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n) // RULE11
      i_clk_en && pin_fall |=> user_seen_q)
      else $error("pin falling edge lost");

endmodule

/* File: testbench/rsm_pin_model.sv */
module rsm_pin_model (
   // drive from the block
   input wire logic i_oe,
   input wire logic i_out,
   // another board device pulling the line low
   input wire logic i_ext_low,
   // resolved line level
   output logic o_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // open-drain line with pull-up: released line reads high
   assign o_level = !((i_oe && !i_out) || i_ext_low);
endmodule

/* File: testbench/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, tick = 1'b0, fault = 1'b0, wd_en = 1'b1, core_only = 1'b0;
   logic brown = 1'b0, brown_en = 1'b0, ext_low = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, nrst_out, nrst_oe, core_n, periph_n, irq, pready, pslverr, pin;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [1:0] tdiv = 2'h0;
   logic er;
   int err_count = 0, total_checks = 0, cyc = 0;
   localparam logic [31:0] KEY = 32'hA5000000;
   // one slow period every four master cycles
   always #25 clk = ~clk;
   always @(posedge clk) begin
      tdiv <= tdiv + 2'h1;
      tick <= (tdiv == 2'h3);
   end
   // cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   rsm_pin_model pin_mdl (.i_oe(nrst_oe), .i_out(nrst_out), .i_ext_low(ext_low), .o_level(pin));
   rsm_reset_state_manager DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
      .i_slow_tick(tick), .i_wdog_fault(fault), .i_watchdog_reset_enable(wd_en),
      .i_watchdog_core_only(core_only), .i_brownout(brown), .i_brownout_reset_enable(brown_en),
      .i_nrst_in(pin), .o_nrst_out(nrst_out), .o_nrst_oe(nrst_oe), .o_core_reset_n(core_n),
      .o_periph_reset_n(periph_n), .o_irq(irq), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_prdata(prdata));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   // one apb transfer; completes at the edge where pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // request holds until the edge that samples pready high
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // watch a fixed window, counting slow ticks under core reset and pin drive; periph low only flagged
   task automatic watch(output logic [31:0] core_t, output logic [31:0] oe_t,
         output logic per_lo);
      core_t = 0;
      oe_t = 0;
      per_lo = 1'b0;
      repeat (300) begin
         @(negedge clk);
         if (!core_n && tick) core_t++;
         if (nrst_oe && tick) oe_t++;
         if (!periph_n) per_lo = 1'b1;
      end
      // hand back on a rising edge so stimulus stays edge aligned
      @(posedge clk);
   endtask
   task automatic t_reset();
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd, 32'h00010000);
      apb(1'b0, rsm_pkg::OFS_MODE, 32'h0);
      chk32(rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk1(er, 1'b1);
      // wrong key leaves mode untouched
      apb(1'b1, rsm_pkg::OFS_MODE, 32'h5A010111);
      apb(1'b0, rsm_pkg::OFS_MODE, 32'h0);
      chk32(rd, 32'h0);
      apb(1'b1, rsm_pkg::OFS_MODE, KEY | 32'h00010111);
      apb(1'b0, rsm_pkg::OFS_MODE, 32'h0);
      chk32(rd, 32'h00010111);
   endtask
   task automatic t_soft();
      logic [31:0] ct, ot;
      logic pl;
      apb(1'b1, rsm_pkg::OFS_MODE, KEY | 32'h00000100);
      apb(1'b1, rsm_pkg::OFS_CMD, 32'h5A000009);
      @(negedge clk);
      chk1(core_n, 1'b1);
      apb(1'b1, rsm_pkg::OFS_CMD, KEY | 32'h00000009);
      watch(ct, ot, pl);
      chk32(ct, 32'd3);
      chk32(ot, 32'd4);
      chk1(pl, 1'b0);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00020700, 32'h00000300);
      // periph only; a command while busy must be ignored
      apb(1'b1, rsm_pkg::OFS_CMD, KEY | 32'h00000004);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk1(rd[17], 1'b1);
      apb(1'b1, rsm_pkg::OFS_CMD, KEY | 32'h00000009);
      watch(ct, ot, pl);
      chk32(ct + ot, 32'd0);
      chk1(pl, 1'b1);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00020700, 32'h00000300);
   endtask
   task automatic t_flags();
      apb(1'b1, rsm_pkg::OFS_MODE, KEY | 32'h00010010);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      ext_low <= 1'b1;
      repeat (12) @(posedge clk);
      ext_low <= 1'b0;
      repeat (8) @(posedge clk);
      chk1(core_n, 1'b1);
      chk1(irq, 1'b1);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00000703, 32'h00000301);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00000703, 32'h00000300);
      chk1(irq, 1'b0);
      brown <= 1'b1;
      repeat (10) @(posedge clk);
      brown <= 1'b0;
      repeat (6) @(posedge clk);
      chk1(irq, 1'b1);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00000003, 32'h00000002);
      // brownout interrupt enable cleared: flag without interrupt
      apb(1'b1, rsm_pkg::OFS_MODE, KEY);
      brown <= 1'b1;
      repeat (10) @(posedge clk);
      brown <= 1'b0;
      repeat (6) @(posedge clk);
      chk1(irq, 1'b0);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk1(rd[1], 1'b1);
   endtask
   task automatic t_wdog();
      logic [31:0] ct, ot;
      logic pl;
      apb(1'b1, rsm_pkg::OFS_MODE, KEY | 32'h00000001);
      fault <= 1'b1;
      watch(ct, ot, pl);
      fault <= 1'b0;
      chk32(ct, 32'd3);
      chk32(ot, 32'd2);
      chk1(pl, 1'b1);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00000700, 32'h00000200);
      core_only <= 1'b1;
      fault <= 1'b1;
      watch(ct, ot, pl);
      fault <= 1'b0;
      chk32(ct, 32'd3);
      chk32(ot, 32'd0);
      chk1(pl, 1'b0);
      // watchdog takes over a running periph-only software reset
      apb(1'b1, rsm_pkg::OFS_CMD, KEY | 32'h00000004);
      fault <= 1'b1;
      watch(ct, ot, pl);
      fault <= 1'b0;
      chk32(ct, 32'd3);
      // let the fault settle low so the next rise is a real edge
      repeat (4) @(posedge clk);
      wd_en <= 1'b0;
      fault <= 1'b1;
      watch(ct, ot, pl);
      fault <= 1'b0;
      chk32(ct + ot, 32'd0);
      // user reset from the pin while enabled
      ext_low <= 1'b1;
      repeat (20) @(posedge clk);
      ext_low <= 1'b0;
      watch(ct, ot, pl);
      chk1(pl, 1'b1);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00000700, 32'h00000400);
      // brownout with its reset enabled: no flag, cause 101
      brown_en <= 1'b1;
      brown <= 1'b1;
      repeat (10) @(posedge clk);
      brown <= 1'b0;
      watch(ct, ot, pl);
      chk1(pl, 1'b1);
      apb(1'b0, rsm_pkg::OFS_STATUS, 32'h0);
      chk32(rd & 32'h00000702, 32'h00000500);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // power-up state: wait until the core is let go
      repeat (40) @(posedge clk);
      chk1(core_n, 1'b1);
      t_reset();
      t_soft();
      t_flags();
      t_wdog();
      report_and_stop();
   end
endmodule
